//--- rtl/boot_cmd_engine.sv
/*
 boot_cmd_engine: serial boot command interpreter with a two-entry
 transmit buffer.
 assumes: a uart beside it delivers received bytes as one-cycle strobes,
 performs rate detection while autobaud_o is high, uses baud_code_o as
 its rate, and a flash controller answers each request with a done pulse.
*/
// Behaviour
// - first accepted byte must be 5AH
// - F0H selects erase of 1000H..FFFFH
// - 30H selects write within 1000H..FFFFH
// - 90H sends 16-bit sum, high first
// - ID command sends 13 byte code
// - status command sends 7 byte code
// - FAH turns read protection on
// - chip or 4K sector erase to FFH
// - protected: only chip erase, clears protection
// - password checked unless blank; mismatch refuses
// - write records bytewise, then send sum
// - protected part never enters write mode
// - echo 5AH, silent on mismatch
// - echo baud code, else A1 A1 A1 A3 A3 A3 62 62 62 halt
// - echo valid command, else A1 A1 A1 A3 A3 A3 63 63 63 halt
// - password addresses and string get no reply
// - password mismatch or rx error halts
// - area byte: high start, low end sector
// - after erase send sum, none on error
// - after sum wait for next command
// - no command reads flash back
// - rates from 9600, codes 04H..28H
// - new rate only after echo sent
`timescale 1ns/1ps
module boot_cmd_engine
   import boot_cmd_pkg::*;
#(
   // arbitrary identification value; bytes 2..5 carry the rom window
   parameter logic [103:0] PRODUCT_ID = 104'h3c_11_1000_ffff_00_00_00_00_00_01_02
)(
   input  wire logic        clk_i,
   input  wire logic        reset_n_i,
   input  wire logic        rx_valid_i,
   input  wire logic [7:0]  rx_data_i,
   input  wire logic        rx_err_i,
   input  wire logic        tx_idle_i,
   input  wire logic        tx_ready_i,
   output logic             tx_valid_o,
   output logic      [7:0]  tx_data_o,
   output logic             autobaud_o,
   output logic      [7:0]  baud_code_o,
   output logic             flash_req_o,
   output logic      [2:0]  flash_op_o,
   output logic      [15:0] flash_addr_o,
   output logic      [7:0]  flash_wdata_o,
   input  wire logic        flash_done_i,
   input  wire logic [7:0]  flash_rdata_i,
   input  wire logic        flash_prot_i,
   output logic             halted_o
);
   // ************************
   // helpers
   // ************************
   function automatic logic baud_ok(input logic [7:0] b);
      case (b)
         8'h04, 8'h05, 8'h06, 8'h07, 8'h0a, 8'h18, 8'h28: baud_ok = 1'b1;
         default: baud_ok = 1'b0;
      endcase
   endfunction

   // no readback command exists; the sum is the only image check
   function automatic st_t cmd_entry(input logic [7:0] b);
      case (b)
         CMD_ERASE: cmd_entry = S_ADDR;
         CMD_WRITE: cmd_entry = S_ADDR;
         CMD_SUM:   cmd_entry = S_SUM;
         CMD_ID:    cmd_entry = S_ID;
         CMD_STAT:  cmd_entry = S_BLANK;
         CMD_PROT:  cmd_entry = S_PROT;
         default:   cmd_entry = S_MATCH;
      endcase
   endfunction

   // ************************
   // engine state
   // ************************
   st_t         state_reg, state_next, ret_reg, ret_next;
   logic [7:0]  cmd_reg, cmd_next, byte_reg, byte_next, len_reg, len_next;
   logic [7:0]  code_reg, code_next, baud_reg, baud_next;
   logic [7:0]  rtype_reg, rtype_next, rsum_reg, rsum_next;
   logic [15:0] cnt_reg, cnt_next, addr_reg, addr_next, sum_reg, sum_next;
   logic [15:0] pca_reg, pca_next, pcs_reg, pcs_next;
   logic [3:0]  last_reg, last_next;
   logic [2:0]  op_reg, op_next;
   logic        blank_reg, blank_next, chip_reg, chip_next;
   logic        push_valid, push_ready;
   logic [7:0]  push_data;
   logic        rx_ok, rx_bad, blank_now;
   logic [3:0]  s_sec;

   assign rx_ok     = rx_valid_i & ~rx_err_i;
   assign rx_bad    = rx_valid_i & rx_err_i;
   assign blank_now = blank_reg & (flash_rdata_i == ERASED);
   assign s_sec     = (rx_data_i[7:4] < SECT_FIRST) ? SECT_FIRST : rx_data_i[7:4];

   always_comb begin
      state_next = state_reg;
      ret_next   = ret_reg;
      cmd_next   = cmd_reg;
      byte_next  = byte_reg;
      len_next   = len_reg;
      code_next  = code_reg;
      baud_next  = baud_reg;
      rtype_next = rtype_reg;
      rsum_next  = rsum_reg;
      cnt_next   = cnt_reg;
      addr_next  = addr_reg;
      sum_next   = sum_reg;
      pca_next   = pca_reg;
      pcs_next   = pcs_reg;
      last_next  = last_reg;
      op_next    = op_reg;
      blank_next = blank_reg;
      chip_next  = chip_reg;
      push_valid = 1'b0;
      push_data  = byte_reg;
      flash_req_o   = 1'b0;
      flash_op_o    = FOP_READ;
      flash_addr_o  = addr_reg;
      flash_wdata_o = byte_reg;
      case (state_reg)
         S_MATCH: begin
            if (rx_ok && rx_data_i == MATCH_BYTE) begin
               byte_next  = rx_data_i;
               ret_next   = S_BAUD;
               state_next = S_ECHO;
            end
         end
         S_ECHO: begin
            push_valid = 1'b1;
            if (push_ready) state_next = ret_reg;
         end
         S_BAUD: begin
            if (rx_ok && baud_ok(rx_data_i)) begin
               byte_next  = rx_data_i;
               ret_next   = S_BAUDSW;
               state_next = S_ECHO;
            end else if (rx_valid_i) begin
               code_next  = ERR_BAUD;
               cnt_next   = '0;
               state_next = S_ERR;
            end
         end
         S_BAUDSW: begin
            if (!tx_valid_o && tx_idle_i) begin
               baud_next  = byte_reg;
               state_next = S_CMD;
            end
         end
         S_CMD: begin
            if (rx_ok && cmd_entry(rx_data_i) != S_MATCH) begin
               cmd_next   = rx_data_i;
               byte_next  = rx_data_i;
               ret_next   = cmd_entry(rx_data_i);
               cnt_next   = '0;
               sum_next   = '0;
               blank_next = 1'b1;
               addr_next  = (rx_data_i == CMD_STAT) ? STAT_LO : FLASH_LO;
               state_next = S_ECHO;
            end else if (rx_valid_i) begin
               code_next  = ERR_CMD;
               cnt_next   = '0;
               state_next = S_ERR;
            end
         end
         S_ADDR: begin
            if (rx_bad) state_next = S_HALT;
            else if (rx_ok) begin
               {pca_next, pcs_next} = {pca_reg[7:0], pcs_reg, rx_data_i};
               cnt_next = cnt_reg + 16'h1;
               if (cnt_reg == 16'h3) begin
                  addr_next  = STAT_LO;
                  state_next = S_BLANK;
               end
            end
         end
         S_BLANK: begin
            flash_req_o = 1'b1;
            if (flash_done_i) begin
               blank_next = blank_now;
               addr_next  = addr_reg + 16'h1;
               if (addr_reg == FLASH_HI) begin
                  cnt_next = '0;
                  if (cmd_reg == CMD_STAT) state_next = S_STAT;
                  else if (blank_now) state_next = S_GATE;
                  else begin
                     addr_next  = pca_reg;
                     state_next = S_PWCNT;
                  end
               end
            end
         end
         S_PWCNT: begin
            flash_req_o = 1'b1;
            if (flash_done_i) begin
               len_next   = flash_rdata_i;
               addr_next  = pcs_reg;
               state_next = (flash_rdata_i == '0) ? S_HALT : S_PWBYTE;
            end
         end
         S_PWBYTE: begin
            if (rx_bad) state_next = S_HALT;
            else if (rx_ok) begin
               byte_next  = rx_data_i;
               state_next = S_PWRD;
            end
         end
         S_PWRD: begin
            flash_req_o = 1'b1;
            if (flash_done_i) begin
               addr_next = addr_reg + 16'h1;
               cnt_next  = cnt_reg + 16'h1;
               if (flash_rdata_i != byte_reg) state_next = S_HALT;
               else if (cnt_reg + 16'h1 == {8'h00, len_reg}) state_next = S_GATE;
               else state_next = S_PWBYTE;
            end
         end
         S_GATE: begin
            cnt_next  = '0;
            rsum_next = '0;
            if (cmd_reg != CMD_WRITE) state_next = S_AREA;
            else state_next = flash_prot_i ? S_HALT : S_REC;
         end
         S_AREA: begin
            if (rx_bad) state_next = S_HALT;
            else if (rx_ok) begin
               chip_next = (s_sec == SECT_FIRST) && (rx_data_i[3:0] == SECT_LAST);
               last_next = rx_data_i[3:0];
               addr_next = {s_sec, SECT_LOW};
               if (rx_data_i[3:0] < s_sec) state_next = S_HALT;
               else if (flash_prot_i && !chip_next) state_next = S_HALT;
               else state_next = S_ERASE;
            end
         end
         S_ERASE: begin
            flash_req_o = 1'b1;
            flash_op_o  = FOP_ERASE;
            if (flash_done_i) begin
               addr_next = addr_reg + SECT_SIZE;
               if (addr_reg[15:12] == last_reg) begin
                  addr_next  = FLASH_LO;
                  sum_next   = '0;
                  op_next    = FOP_UNPROT;
                  ret_next   = S_SUM;
                  state_next = chip_reg ? S_FOP : S_SUM;
               end
            end
         end
         S_SUM: begin
            flash_req_o = 1'b1;
            if (flash_done_i) begin
               sum_next  = sum_reg + {8'h00, flash_rdata_i};
               addr_next = addr_reg + 16'h1;
               if (addr_reg == FLASH_HI) begin
                  cnt_next   = '0;
                  state_next = S_SEND;
               end
            end
         end
         S_SEND: begin
            push_valid = 1'b1;
            push_data  = cnt_reg[0] ? sum_reg[7:0] : sum_reg[15:8];
            if (push_ready) begin
               cnt_next = cnt_reg + 16'h1;
               if (cnt_reg[0]) state_next = S_CMD;
            end
         end
         S_ID: begin
            push_valid = 1'b1;
            push_data  = PRODUCT_ID[8*(ID_LEN-1-int'(cnt_reg[3:0])) +: 8];
            if (push_ready) begin
               cnt_next = cnt_reg + 16'h1;
               if (cnt_reg == 16'(ID_LEN - 1)) state_next = S_CMD;
            end
         end
         S_STAT: begin
            push_valid = 1'b1;
            push_data  = '0;
            if (cnt_reg == '0) push_data = blank_reg ? ERASED : 8'h00;
            if (cnt_reg == 16'h1) push_data = {7'h00, flash_prot_i};
            if (push_ready) begin
               cnt_next = cnt_reg + 16'h1;
               if (cnt_reg == 16'(STAT_LEN - 1)) state_next = S_CMD;
            end
         end
         S_ERR: begin
            push_valid = 1'b1;
            push_data  = err_byte(cnt_reg[3:0], code_reg);
            if (push_ready) begin
               cnt_next = cnt_reg + 16'h1;
               if (cnt_reg == ERR_LAST) state_next = S_HALT;
            end
         end
         S_FOP: begin
            flash_req_o = 1'b1;
            flash_op_o  = op_reg;
            if (flash_done_i) begin
               if (op_reg == FOP_PROG) addr_next = addr_reg + 16'h1;
               state_next = ret_reg;
            end
         end
         S_REC: begin
            if (rx_bad) state_next = S_HALT;
            else if (rx_ok) begin
               rsum_next = rsum_reg + rx_data_i;
               cnt_next  = cnt_reg + 16'h1;
               if (cnt_reg == '0) len_next = rx_data_i;
               else if (cnt_reg == 16'h1) addr_next = {rx_data_i, addr_reg[7:0]};
               else if (cnt_reg == 16'h2) addr_next = {addr_reg[15:8], rx_data_i};
               else if (cnt_reg == 16'h3) begin
                  rtype_next = rx_data_i;
                  if (rx_data_i != REC_DATA && rx_data_i != REC_END) state_next = S_HALT;
               end else if (cnt_reg < {8'h00, len_reg} + REC_HDR) begin
                  byte_next  = rx_data_i;
                  op_next    = FOP_PROG;
                  ret_next   = S_REC;
                  state_next = (addr_reg < FLASH_LO) ? S_HALT : S_FOP;
               end else begin
                  cnt_next = '0;
                  if (rsum_next != '0) state_next = S_HALT;
                  else if (rtype_reg == REC_END) begin
                     addr_next  = FLASH_LO;
                     sum_next   = '0;
                     state_next = S_SUM;
                  end
               end
            end
         end
         S_PROT: begin
            flash_req_o = 1'b1;
            flash_op_o  = FOP_PROT;
            if (flash_done_i) state_next = S_CMD;
         end
         S_HALT: state_next = S_HALT;
         default: state_next = S_HALT;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         state_reg <= S_MATCH;
         ret_reg   <= S_MATCH;
         cmd_reg   <= '0;
         byte_reg  <= '0;
         len_reg   <= '0;
         code_reg  <= '0;
         baud_reg  <= BAUD_INIT;
         rtype_reg <= '0;
         rsum_reg  <= '0;
         cnt_reg   <= '0;
         addr_reg  <= '0;
         sum_reg   <= '0;
         pca_reg   <= '0;
         pcs_reg   <= '0;
         last_reg  <= '0;
         op_reg    <= FOP_READ;
         blank_reg <= 1'b0;
         chip_reg  <= 1'b0;
      end else begin
         state_reg <= state_next;
         ret_reg   <= ret_next;
         cmd_reg   <= cmd_next;
         byte_reg  <= byte_next;
         len_reg   <= len_next;
         code_reg  <= code_next;
         baud_reg  <= baud_next;
         rtype_reg <= rtype_next;
         rsum_reg  <= rsum_next;
         cnt_reg   <= cnt_next;
         addr_reg  <= addr_next;
         sum_reg   <= sum_next;
         pca_reg   <= pca_next;
         pcs_reg   <= pcs_next;
         last_reg  <= last_next;
         op_reg    <= op_next;
         blank_reg <= blank_next;
         chip_reg  <= chip_next;
      end
   end

   assign autobaud_o  = (state_reg == S_MATCH);
   assign baud_code_o = baud_reg;
   assign halted_o    = (state_reg == S_HALT);

   // ************************
   // two-entry tx buffer
   // ************************
   // engine stalls on a full buffer, so a slow uart drops nothing
   logic [7:0] buf_reg [2];
   logic [7:0] buf_next [2];
   logic       wr_reg, wr_next, rd_reg, rd_next;
   logic [1:0] fill_reg, fill_next;

   assign push_ready = (fill_reg != 2'h2);
   assign tx_valid_o = (fill_reg != 2'h0);
   assign tx_data_o  = buf_reg[rd_reg];

   always_comb begin
      buf_next  = buf_reg;
      wr_next   = wr_reg;
      rd_next   = rd_reg;
      fill_next = fill_reg;
      if (push_valid && push_ready) begin
         buf_next[wr_reg] = push_data;
         wr_next          = ~wr_reg;
      end
      if (tx_valid_o && tx_ready_i) rd_next = ~rd_reg;
      fill_next = fill_reg + 2'(push_valid && push_ready) - 2'(tx_valid_o && tx_ready_i);
   end

   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         buf_reg  <= '{default: 8'h00};
         wr_reg   <= 1'b0;
         rd_reg   <= 1'b0;
         fill_reg <= 2'h0;
      end else begin
         buf_reg  <= buf_next;
         wr_reg   <= wr_next;
         rd_reg   <= rd_next;
         fill_reg <= fill_next;
      end
   end
endmodule

//--- rtl/boot_cmd_pkg.sv
/*
 boot_cmd_pkg: byte values, flash window, error codes, flash operation
 codes and the one-hot state set of the serial boot command engine.
 assumes: an 8-bit byte stream and a 16-bit flash address space.
*/
package boot_cmd_pkg;
   // ************************
   // protocol bytes
   // ************************
   localparam logic [7:0] MATCH_BYTE = 8'h5a;
   localparam logic [7:0] CMD_ERASE  = 8'hf0;
   localparam logic [7:0] CMD_WRITE  = 8'h30;
   localparam logic [7:0] CMD_SUM    = 8'h90;
   localparam logic [7:0] CMD_ID     = 8'hc0;
   localparam logic [7:0] CMD_STAT   = 8'hc3;
   localparam logic [7:0] CMD_PROT   = 8'hfa;
   localparam logic [7:0] BAUD_INIT  = 8'h28;
   localparam logic [7:0] ERR_LEAD_A = 8'ha1;
   localparam logic [7:0] ERR_LEAD_B = 8'ha3;
   localparam logic [7:0] ERR_BAUD   = 8'h62;
   localparam logic [7:0] ERR_CMD    = 8'h63;
   localparam logic [3:0] ERR_SPLIT1 = 4'h3;
   localparam logic [3:0] ERR_SPLIT2 = 4'h6;
   localparam logic [15:0] ERR_LAST  = 16'h0008;
   localparam logic [7:0] REC_DATA   = 8'h00;
   localparam logic [7:0] REC_END    = 8'h01;
   localparam logic [15:0] REC_HDR   = 16'h0004;
   // ************************
   // flash window
   // ************************
   localparam logic [15:0] FLASH_LO   = 16'h1000;
   localparam logic [15:0] FLASH_HI   = 16'hffff;
   localparam logic [15:0] STAT_LO    = 16'hffe0;
   localparam logic [7:0]  ERASED     = 8'hff;
   localparam logic [3:0]  SECT_FIRST = 4'h1;
   localparam logic [3:0]  SECT_LAST  = 4'hf;
   localparam logic [11:0] SECT_LOW   = 12'h000;
   localparam logic [15:0] SECT_SIZE  = 16'h1000;
   localparam logic [2:0] FOP_READ   = 3'h0;
   localparam logic [2:0] FOP_PROG   = 3'h1;
   localparam logic [2:0] FOP_ERASE  = 3'h2;
   localparam logic [2:0] FOP_PROT   = 3'h3;
   localparam logic [2:0] FOP_UNPROT = 3'h4;
   localparam int ID_LEN   = 13;
   localparam int STAT_LEN = 7;

   typedef enum logic [21:0] {
      S_MATCH = 22'h000001, S_ECHO  = 22'h000002, S_BAUD  = 22'h000004,
      S_BAUDSW= 22'h000008, S_CMD   = 22'h000010, S_ADDR  = 22'h000020,
      S_BLANK = 22'h000040, S_PWCNT = 22'h000080, S_PWBYTE= 22'h000100,
      S_PWRD  = 22'h000200, S_GATE  = 22'h000400, S_AREA  = 22'h000800,
      S_ERASE = 22'h001000, S_SUM   = 22'h002000, S_SEND  = 22'h004000,
      S_ID    = 22'h008000, S_STAT  = 22'h010000, S_ERR   = 22'h020000,
      S_FOP   = 22'h040000, S_REC   = 22'h080000, S_PROT  = 22'h100000,
      S_HALT  = 22'h200000
   } st_t;

   function automatic logic [7:0] err_byte(input logic [3:0] idx, input logic [7:0] code);
      err_byte = (idx < ERR_SPLIT1) ? ERR_LEAD_A : (idx < ERR_SPLIT2) ? ERR_LEAD_B : code;
   endfunction
endpackage

//--- dv/boot_cmd_engine_asserts.sv
/*
 boot_cmd_engine_asserts: port assertions for the boot command engine.
 assumes: bound onto boot_cmd_engine; one clock, sync active-low reset.
*/
`timescale 1ns/1ps
module boot_cmd_engine_asserts
   import boot_cmd_pkg::*;
(
   input wire logic        clk_i,
   input wire logic        reset_n_i,
   input wire logic        rx_valid_i,
   input wire logic [7:0]  rx_data_i,
   input wire logic        rx_err_i,
   input wire logic        tx_idle_i,
   input wire logic        tx_ready_i,
   input wire logic        tx_valid_o,
   input wire logic [7:0]  tx_data_o,
   input wire logic        autobaud_o,
   input wire logic [7:0]  baud_code_o,
   input wire logic        flash_req_o,
   input wire logic [2:0]  flash_op_o,
   input wire logic [15:0] flash_addr_o,
   input wire logic        flash_done_i,
   input wire logic        halted_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);
   // ************************
   // sequences
   // ************************
   sequence s_match_in;
      autobaud_o && rx_valid_i && !rx_err_i && rx_data_i == MATCH_BYTE;
   endsequence
   sequence s_echo_out;
      ##2 tx_valid_o && tx_data_o == MATCH_BYTE;
   endsequence
   // ************************
   // assertions
   // ************************
   chk_reset_vals: assert property (disable iff (1'b0) !reset_n_i |=>
      !tx_valid_o && autobaud_o && baud_code_o == BAUD_INIT && !flash_req_o && !halted_o)
      else $error("outputs wrong after reset");
   chk_match_echo: assert property (s_match_in |-> s_echo_out)
      else $error("match byte not echoed");
   chk_nomatch_quiet: assert property (autobaud_o && rx_valid_i &&
      rx_data_i != MATCH_BYTE |=> autobaud_o && !tx_valid_o)
      else $error("non-match byte answered");
   chk_halt_stays: assert property (halted_o |=> halted_o)
      else $error("halt left without reset");
   chk_halt_silent: assert property (halted_o && !tx_valid_o |=> !tx_valid_o && !flash_req_o)
      else $error("halted engine active");
   chk_baud_switch: assert property ($changed(baud_code_o) |->
      !$past(tx_valid_o) && $past(tx_idle_i))
      else $error("rate changed before echo left");
   chk_baud_legal: assert property (baud_code_o inside {8'h04, 8'h05, 8'h06, 8'h07,
      8'h0a, 8'h18, 8'h28})
      else $error("illegal rate code in force");
   chk_tx_hold: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o))
      else $error("tx byte dropped in stall");
   chk_req_hold: assert property (flash_req_o && !flash_done_i |=>
      flash_req_o && $stable(flash_op_o) && $stable(flash_addr_o))
      else $error("flash request not held");
   chk_erase_base: assert property (flash_req_o && flash_op_o == FOP_ERASE |->
      flash_addr_o[11:0] == SECT_LOW && flash_addr_o >= FLASH_LO)
      else $error("erase outside window");
endmodule

//--- dv/flash_model.sv
/*
 flash_model: behavioural flash controller beside the boot engine.
 assumes: one request at a time, held until the done pulse.
*/
`timescale 1ns/1ps
module flash_model
   import boot_cmd_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        req_i,
   input  wire logic [2:0]  op_i,
   input  wire logic [15:0] addr_i,
   input  wire logic [7:0]  wdata_i,
   output logic             done_o,
   output logic      [7:0]  rdata_o,
   output logic             prot_o
);
   logic [7:0] mem [65536];
   logic       busy = 1'b0;
   initial begin
      foreach (mem[i]) mem[i] = ERASED;
      mem[16'h2000] = 8'h00; // one used byte, so an erase shows in the sum
      prot_o = 1'b0;
   end
   // reads answer at once to keep scans short
   assign done_o  = req_i && (op_i == FOP_READ || busy);
   assign rdata_o = done_o ? mem[addr_i] : ~mem[addr_i];
   always @(posedge clk_i) begin
      busy <= req_i && op_i != FOP_READ && !busy;
      if (busy) begin
         case (op_i)
            FOP_PROG:   mem[addr_i] <= mem[addr_i] & wdata_i;
            FOP_ERASE:  for (int i = 0; i < 4096; i++) mem[addr_i + 16'(i)] = ERASED;
            FOP_PROT:   prot_o <= 1'b1;
            FOP_UNPROT: prot_o <= 1'b0;
            default: ;
         endcase
      end
   end
endmodule

//--- dv/testbench.sv
/*
 testbench: self-checking bench for the boot command engine.
 assumes: flash_model stands in for the flash controller; the bench
 plays the uart and the remote write controller at byte level.
*/
`timescale 1ns/1ps
module testbench
   import boot_cmd_pkg::*;
;
   // arbitrary identification value, rom window in bytes 2..5
   localparam logic [103:0] PID = 104'h0a_0b_1000_ffff_0c_0d_0e_0f_10_11_12;
   logic        clk_i = 0, reset_n_i = 0, rx_valid_i = 0, rx_err_i = 0;
   logic        tx_idle_i = 1, tx_ready_i = 0, hold = 0;
   logic        tx_valid_o, autobaud_o, flash_req_o, flash_done_i, flash_prot_i, halted_o;
   logic [7:0]  rx_data_i = 8'h00, tx_data_o, baud_code_o, flash_wdata_o, flash_rdata_i;
   logic [2:0]  flash_op_o;
   logic [15:0] flash_addr_o;
   logic [1:0]  cnt = 2'h0;
   logic [7:0]  q [$];
   int          error_cnt = 0, tests_run = 0;

   boot_cmd_engine #(.PRODUCT_ID(PID)) i_dut (.clk_i(clk_i), .reset_n_i(reset_n_i),
      .rx_valid_i(rx_valid_i), .rx_data_i(rx_data_i), .rx_err_i(rx_err_i),
      .tx_idle_i(tx_idle_i), .tx_ready_i(tx_ready_i), .tx_valid_o(tx_valid_o),
      .tx_data_o(tx_data_o), .autobaud_o(autobaud_o), .baud_code_o(baud_code_o),
      .flash_req_o(flash_req_o), .flash_op_o(flash_op_o), .flash_addr_o(flash_addr_o),
      .flash_wdata_o(flash_wdata_o), .flash_done_i(flash_done_i),
      .flash_rdata_i(flash_rdata_i), .flash_prot_i(flash_prot_i), .halted_o(halted_o));
   flash_model i_flash (.clk_i(clk_i), .req_i(flash_req_o), .op_i(flash_op_o),
      .addr_i(flash_addr_o), .wdata_i(flash_wdata_o), .done_o(flash_done_i),
      .rdata_o(flash_rdata_i), .prot_o(flash_prot_i));

   always #12.5 clk_i = ~clk_i;
   // one stalled cycle in four keeps the two-entry buffer under pressure
   always @(posedge clk_i) begin
      cnt <= cnt + 2'h1;
      tx_ready_i <= #1 (cnt != 2'h3) && !hold;
      tx_idle_i <= #1 !tx_valid_o;
   end
   always @(posedge clk_i) if (tx_valid_o && tx_ready_i) q.push_back(tx_data_o);

   // ************************
   // helpers
   // ************************
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         error_cnt++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic put(input logic [7:0] b, input logic e = 1'b0);
      repeat (4) @(posedge clk_i);
      #1 rx_valid_i = 1'b1;
      rx_data_i = b;
      rx_err_i = e;
      @(posedge clk_i);
      #1 rx_valid_i = 1'b0;
      rx_data_i = ~b;
      rx_err_i = 1'b0;
   endtask
   task automatic get(input logic [7:0] exp);
      int n;
      for (n = 0; n < 70000 && q.size() == 0; n++) @(posedge clk_i);
      if (q.size() == 0) begin
         error_cnt++;
         report_and_stop();
      end
      chk(q.pop_front(), exp);
   endtask
   task automatic quiet(input int n);
      repeat (n) @(posedge clk_i);
      chk(16'(q.size()), 16'h0000);
   endtask
   task automatic settle(input bit prot, input logic v);
      int n;
      for (n = 0; n < 1000 && (prot ? flash_prot_i : halted_o) !== v; n++) @(posedge clk_i);
      chk(prot ? flash_prot_i : halted_o, v);
      if (n == 1000) report_and_stop();
   endtask
   task automatic start;
      @(posedge clk_i);
      #1 reset_n_i = 1'b0;
      repeat (2) @(posedge clk_i);
      #1 reset_n_i = 1'b1;
      q.delete();
      put(8'h33);
      quiet(40);
      put(MATCH_BYTE);
      get(MATCH_BYTE);
   endtask
   task automatic setup(input logic [7:0] code);
      int n;
      start();
      put(code);
      get(code);
      for (n = 0; n < 1000 && baud_code_o !== code; n++) @(posedge clk_i);
      chk(baud_code_o, code);
      if (n == 1000) report_and_stop();
   endtask
   task automatic cmd(input logic [7:0] c);
      put(c);
      get(c);
   endtask
   task automatic addrs;
      for (int i = 0; i < 4; i++) begin
         put(i[0] ? 8'h00 : 8'h10);
         quiet(300);
      end
   endtask
   task automatic err(input logic [7:0] code);
      for (int i = 0; i < 9; i++) get(i < 3 ? ERR_LEAD_A : i < 6 ? ERR_LEAD_B : code);
      settle(0, 1'b1);
      put(MATCH_BYTE);
      quiet(100);
   endtask
   task automatic stat(input logic p);
      cmd(CMD_STAT);
      get(ERASED);
      get({7'h00, p});
      repeat (5) get(8'h00);
   endtask

   // ************************
   // scenarios
   // ************************
   task automatic t_baud;
      logic [7:0] codes [7];
      codes = '{8'h04, 8'h05, 8'h06, 8'h07, 8'h0a, 8'h18, 8'h28};
      foreach (codes[i]) setup(codes[i]);
      $display("test baud codes done");
   endtask
   task automatic t_bad;
      start();
      put(BAUD_INIT, 1'b1);
      err(ERR_BAUD);
      start();
      put(8'h11);
      err(ERR_BAUD);
      setup(BAUD_INIT);
      put(8'h55);
      err(ERR_CMD);
      $display("test bad codes done");
   endtask
   task automatic t_main;
      logic [31:0] s;
      s = (32'h10000 - FLASH_LO) * ERASED;
      setup(8'h04);
      cmd(CMD_ID);
      #1 hold = 1'b1;
      repeat (60) @(posedge clk_i);
      #1 hold = 1'b0;
      for (int i = 0; i < ID_LEN; i++) get(PID[103 - 8 * i -: 8]);
      cmd(CMD_PROT);
      settle(1, 1'b1);
      stat(1'b1);
      cmd(CMD_ERASE);
      addrs();
      put(8'h1f);
      get(s[15:8]);
      get(s[7:0]);
      chk(flash_prot_i, 1'b0);
      stat(1'b0);
      $display("test command set done");
   endtask
   task automatic t_refuse;
      setup(BAUD_INIT);
      cmd(CMD_PROT);
      settle(1, 1'b1);
      cmd(CMD_WRITE);
      addrs();
      settle(0, 1'b1);
      quiet(50);
      setup(BAUD_INIT);
      cmd(CMD_ERASE);
      addrs();
      put(8'h23);
      settle(0, 1'b1);
      chk(flash_prot_i, 1'b1);
      $display("test protection done");
   endtask

   initial begin
      t_baud();
      t_bad();
      t_main();
      t_refuse();
      report_and_stop();
   end
endmodule

bind boot_cmd_engine boot_cmd_engine_asserts i_chk (.clk_i(clk_i), .reset_n_i(reset_n_i),
   .rx_valid_i(rx_valid_i), .rx_data_i(rx_data_i), .rx_err_i(rx_err_i),
   .tx_idle_i(tx_idle_i), .tx_ready_i(tx_ready_i), .tx_valid_o(tx_valid_o),
   .tx_data_o(tx_data_o), .autobaud_o(autobaud_o), .baud_code_o(baud_code_o),
   .flash_req_o(flash_req_o), .flash_op_o(flash_op_o), .flash_addr_o(flash_addr_o),
   .flash_done_i(flash_done_i), .halted_o(halted_o));
